// File: include/rsse_defines.svh
// Constants for the rotate / set / sleep execute block.
// Assumes a single instruction clock; no bus master beyond classic Wishbone.
// Functional notes
// [RULE1] Word 0011 00da ffff ffff decodes as rotate right through carry, one cycle.
// [RULE2] Through-carry rotate: bits shift down, bit0 to carry, old carry to bit7.
// [RULE3] Through-carry rotate updates carry, negative, zero; others kept.
// [RULE4] Destination bit 0 writes working register, 1 writes the file register.
// [RULE5] Access bit 0 uses access bank; 1 uses bank select register.
// [RULE6] Word 0100 00da decodes as plain rotate right; updates negative and zero only.
// [RULE7] Word 0110 100a writes ffh to the file register, flags unchanged.
// [RULE8] Sleep clears the power-down flag and sets the timeout flag.
// [RULE9] Sleep resets the watchdog counter to 00h and clears its postscaler.
// [RULE10] Word 0003h is sleep: no operand read, halts in the last quarter.
// [RULE11] Watchdog wake-up from sleep clears the timeout flag.
// [RULE12] Each instruction runs decode, read, process, write quarters in order.
// [RULE13] Operands are 8 bits; negative is bit7, zero when result is all zero.
`ifndef RSSE_DEFINES_SVH
`define RSSE_DEFINES_SVH
// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define RSSE_OP_RRC      6'h0c
`define RSSE_OP_RRN      6'h10
`define RSSE_OP_SET      7'h34
`define RSSE_WORD_SLEEP  16'h0003
`define RSSE_ALL_ONES    8'hff
`define RSSE_WDT_CLEAR   8'h00
`define RSSE_PS_CLEAR    8'h00
// ----------------------------------------
// Register map (word indices, decoded from wb_adr_i[5:2])
// ----------------------------------------
`define RSSE_ADR_INSTR   4'h0
`define RSSE_ADR_STATUS  4'h1
`define RSSE_ADR_WREG    4'h2
`define RSSE_ADR_BANK    4'h3
`define RSSE_ADR_WDT     4'h4
`define RSSE_ADR_CTRL    4'h5
`define RSSE_ADR_FADDR   4'h6
`define RSSE_ADR_FDATA   4'h7
// ----------------------------------------
// Status bit positions and reset values
// ----------------------------------------
`define RSSE_ST_C        0
`define RSSE_ST_Z        2
`define RSSE_ST_N        4
`define RSSE_ST_PD       5
`define RSSE_ST_TO       6
`define RSSE_ST_SLEEP    7
`define RSSE_STATUS_RST  8'h60
`define RSSE_WREG_RST    8'h00
`define RSSE_BANK_RST    4'h0
`define RSSE_ACCESS_SPLIT 8'h80
`define RSSE_ACCESS_HIGH 4'hf
`endif

// File: include/rsse_pkg.sv
// Types for the rotate / set / sleep execute block.
// Assumes rsse_defines.svh supplies the numeric constants.
package rsse_pkg;
  typedef enum logic [1:0] {
    RSSE_Q1 = 2'b00,
    RSSE_Q2 = 2'b01,
    RSSE_Q3 = 2'b10,
    RSSE_Q4 = 2'b11
  } rsse_q_e;
  typedef enum logic [2:0] {
    RSSE_OP_NONE = 3'b000,
    RSSE_OP_ROTATE_RIGHT_THROUGH_CARRY = 3'b001,
    RSSE_OP_RRNF = 3'b010,
    RSSE_OP_SET_REGISTER_ALL_ONES = 3'b011,
    RSSE_OP_SLP  = 3'b100
  } rsse_op_e;
endpackage : rsse_pkg

// File: hdl/rsse_decode.sv
// Instruction word decoder.
// Assumes a full 16-bit word presented at once.
`timescale 1ns/100ps
`include "rsse_defines.svh"
module rsse_decode
  import rsse_pkg::*;
(
  // Word in
  input  wire logic [15:0] word,
  // Decoded fields
  output rsse_op_e         op,
  output logic             destFile,
  output logic             useBank,
  output logic [7:0]       fileAdr
);
  wire isRrc   = (word[15:10] == `RSSE_OP_RRC);   // [RULE1]
  wire isRrn   = (word[15:10] == `RSSE_OP_RRN);   // [RULE6]
  wire isSet   = (word[15:9] == `RSSE_OP_SET);    // [RULE7]
  wire isSleep = (word == `RSSE_WORD_SLEEP);      // [RULE10]
  assign op = isRrc ? RSSE_OP_ROTATE_RIGHT_THROUGH_CARRY :
              isRrn ? RSSE_OP_RRNF :
              isSet ? RSSE_OP_SET_REGISTER_ALL_ONES :
              isSleep ? RSSE_OP_SLP : RSSE_OP_NONE;
  assign destFile = word[9] | isSet;
  assign useBank  = word[8];
  assign fileAdr  = word[7:0];
endmodule : rsse_decode

// File: hdl/rsse_alu.sv
// Rotate and set datapath with flag results.
// Assumes 8-bit operand and current status byte.
`timescale 1ns/100ps
`include "rsse_defines.svh"
module rsse_alu
  import rsse_pkg::*;
(
  // Operands
  input  rsse_op_e         op,
  input  wire logic [7:0]  operand,
  input  wire logic [7:0]  statusIn,
  // Results
  output logic [7:0]       result,
  output logic [7:0]       statusOut
);
  wire carryIn = statusIn[`RSSE_ST_C];
  wire [7:0] rrc = {carryIn, operand[7:1]};        // [RULE2]
  wire [7:0] rrn = {operand[0], operand[7:1]};     // [RULE6]
  assign result = (op == RSSE_OP_ROTATE_RIGHT_THROUGH_CARRY) ? rrc :
                  (op == RSSE_OP_RRNF) ? rrn :
                  (op == RSSE_OP_SET_REGISTER_ALL_ONES) ? `RSSE_ALL_ONES : operand; // [RULE7]
  wire rot = (op == RSSE_OP_ROTATE_RIGHT_THROUGH_CARRY) || (op == RSSE_OP_RRNF);
  wire zeroF = (result == 8'h00);                  // [RULE13]
  always_comb begin
    statusOut = statusIn;
    if (rot) begin
      statusOut[`RSSE_ST_N] = result[7];           // [RULE13]
      statusOut[`RSSE_ST_Z] = zeroF;
    end
    if (op == RSSE_OP_ROTATE_RIGHT_THROUGH_CARRY) begin
      statusOut[`RSSE_ST_C] = operand[0];          // [RULE3]
    end
  end
endmodule : rsse_alu

// File: hdl/rsse_core.sv
// Top of the rotate / set / sleep executor with a Wishbone slave.
// Assumes classic Wishbone; file register storage is a 16-entry flop array.
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "rsse_defines.svh"
module rsse_core
  import rsse_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Watchdog side
  input  wire logic        wdtWake,
  output logic [7:0]       wdtCount,
  output logic [7:0]       wdtPostscale,
  output logic             sleeping,
  output logic             busy
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  rsse_q_e     q_r;
  logic        busy_r;
  logic [15:0] instr_r;
  logic [7:0]  status_r;
  logic [7:0]  wreg_r;
  logic [3:0]  bank_r;
  logic [7:0]  wdt_r;
  logic [7:0]  ps_r;
  logic [7:0]  operand_r;
  logic [7:0]  result_r;
  logic [7:0]  statNew_r;
  logic [3:0]  faddr_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [7:0]  fileMem [0:15];
  // ----------------------------------------
  // Decode and datapath
  // ----------------------------------------
  rsse_op_e    op;
  logic        destFile;
  logic        useBank;
  logic [7:0]  fileAdr;
  logic [7:0]  aluRes;
  logic [7:0]  aluStat;
  rsse_decode u_dec (
    .word     (instr_r),
    .op       (op),
    .destFile (destFile),
    .useBank  (useBank),
    .fileAdr  (fileAdr)
  );
  rsse_alu u_alu (
    .op        (op),
    .operand   (operand_r),
    .statusIn  (status_r),
    .result    (aluRes),
    .statusOut (aluStat)
  );
  // Bank select gives the bank nibble; access bank splits at 80h
  function automatic logic [3:0] bankOf(input logic ub, input logic [7:0] a,
                                        input logic [3:0] b);
    if (ub) begin
      return b;
    end
    return (a < `RSSE_ACCESS_SPLIT) ? 4'h0 : `RSSE_ACCESS_HIGH;
  endfunction : bankOf
  // Storage holds only 16 entries, indexed by bank nibble XOR low address nibble
  wire [3:0] selBank = bankOf(useBank, fileAdr, bank_r);  // [RULE5]
  wire [3:0] memIdx  = selBank ^ fileAdr[3:0];
  wire isSleepOp = (op == RSSE_OP_SLP);
  wire isRot     = (op == RSSE_OP_ROTATE_RIGHT_THROUGH_CARRY) || (op == RSSE_OP_RRNF);
  wire writesMem = (op == RSSE_OP_SET_REGISTER_ALL_ONES) || (isRot && destFile); // [RULE4]
  wire writesW   = isRot && !destFile;                          // [RULE4]
  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------
  wire req     = wb_cyc_i && wb_stb_i && !ack_r;
  wire wrReq   = req && wb_we_i && wb_sel_i[0];
  wire [3:0] regSel = wb_adr_i[5:2];
  wire startEx = wrReq && (regSel == `RSSE_ADR_INSTR) && !busy_r && !status_r[`RSSE_ST_SLEEP];
  wire wrBank  = wrReq && (regSel == `RSSE_ADR_BANK);
  wire wrW     = wrReq && (regSel == `RSSE_ADR_WREG) && !busy_r;
  wire wrFad   = wrReq && (regSel == `RSSE_ADR_FADDR);
  wire wrFdat  = wrReq && (regSel == `RSSE_ADR_FDATA) && !busy_r;
  wire [31:0] rdMux =
    (regSel == `RSSE_ADR_INSTR)  ? {16'h0000, instr_r} :
    (regSel == `RSSE_ADR_STATUS) ? {24'h000000, status_r} :
    (regSel == `RSSE_ADR_WREG)   ? {24'h000000, wreg_r} :
    (regSel == `RSSE_ADR_BANK)   ? {28'h0000000, bank_r} :
    (regSel == `RSSE_ADR_WDT)    ? {16'h0000, ps_r, wdt_r} :
    (regSel == `RSSE_ADR_CTRL)   ? {31'h00000000, busy_r} :
    (regSel == `RSSE_ADR_FADDR)  ? {28'h0000000, faddr_r} :
    (regSel == `RSSE_ADR_FDATA)  ? {24'h000000, fileMem[faddr_r]} : 32'h00000000;
  // ----------------------------------------
  // Quarter-cycle sequencer
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q_r    <= RSSE_Q1;
      busy_r <= 1'b0;
    end else if (clkEn) begin
      if (startEx) begin
        busy_r <= 1'b1;
        q_r    <= RSSE_Q1;
      end else if (busy_r) begin
        case (q_r)                                 // [RULE12]
          RSSE_Q1: q_r <= RSSE_Q2;
          RSSE_Q2: q_r <= RSSE_Q3;
          RSSE_Q3: q_r <= RSSE_Q4;
          RSSE_Q4: begin
            q_r    <= RSSE_Q1;
            busy_r <= 1'b0;
          end
          default: q_r <= RSSE_Q1;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Datapath registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      instr_r   <= 16'h0000;
      operand_r <= 8'h00;
      result_r  <= 8'h00;
      statNew_r <= `RSSE_STATUS_RST;
    end else if (clkEn) begin
      if (startEx) begin
        instr_r <= wb_dat_i[15:0];
      end
      if (busy_r && q_r == RSSE_Q2 && !isSleepOp) begin
        operand_r <= fileMem[memIdx];              // [RULE10]
      end
      if (busy_r && q_r == RSSE_Q3) begin
        result_r  <= aluRes;
        statNew_r <= aluStat;
      end
    end
  end
  // ----------------------------------------
  // Write-back, status and watchdog
  // ----------------------------------------
  wire q4 = busy_r && (q_r == RSSE_Q4);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_r <= `RSSE_STATUS_RST;
      wreg_r   <= `RSSE_WREG_RST;
      wdt_r    <= `RSSE_WDT_CLEAR;
      ps_r     <= `RSSE_PS_CLEAR;
    end else if (clkEn) begin
      if (q4 && isRot) begin
        status_r[`RSSE_ST_N] <= statNew_r[`RSSE_ST_N];
        status_r[`RSSE_ST_Z] <= statNew_r[`RSSE_ST_Z];
        status_r[`RSSE_ST_C] <= statNew_r[`RSSE_ST_C]; // [RULE3]
      end
      if (q4 && isSleepOp) begin
        status_r[`RSSE_ST_PD]    <= 1'b0;          // [RULE8]
        status_r[`RSSE_ST_TO]    <= 1'b1;
        status_r[`RSSE_ST_SLEEP] <= 1'b1;          // [RULE10]
        wdt_r <= `RSSE_WDT_CLEAR;                  // [RULE9]
        ps_r  <= `RSSE_PS_CLEAR;
      end else if (status_r[`RSSE_ST_SLEEP] && wdtWake) begin
        status_r[`RSSE_ST_TO]    <= 1'b0;          // [RULE11]
        status_r[`RSSE_ST_SLEEP] <= 1'b0;
      end else if (!status_r[`RSSE_ST_SLEEP]) begin
        {ps_r, wdt_r} <= {ps_r, wdt_r} + 16'h0001;
      end
      if (q4 && writesW) begin
        wreg_r <= result_r;
      end else if (wrW) begin
        wreg_r <= wb_dat_i[7:0];
      end
    end
  end
  // ----------------------------------------
  // File register array and bus side
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (clkEn) begin
      if (q4 && writesMem) begin
        fileMem[memIdx] <= result_r;               // [RULE4]
      end else if (wrFdat) begin
        fileMem[faddr_r] <= wb_dat_i[7:0];
      end
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bank_r  <= `RSSE_BANK_RST;
      faddr_r <= 4'h0;
      ack_r   <= 1'b0;
      rdat_r  <= 32'h00000000;
    end else if (clkEn) begin
      ack_r  <= req;
      rdat_r <= rdMux;
      if (wrBank) begin
        bank_r <= wb_dat_i[3:0];
      end
      if (wrFad) begin
        faddr_r <= wb_dat_i[3:0];
      end
    end
  end
  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = rdat_r;
  assign wdtCount     = wdt_r;
  assign wdtPostscale = ps_r;
  assign sleeping     = status_r[`RSSE_ST_SLEEP];
  assign busy         = busy_r;
endmodule : rsse_core

// File: sim/rsse_core_monitor.sv
// Concurrent checks on the executor's ports.
// Assumes a bind to rsse_core and a single clock domain.
`timescale 1ns/100ps
`include "rsse_defines.svh"
module rsse_core_monitor (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       clkEn,
  // Wishbone
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic       wb_ack_o,
  // Watchdog side
  input wire logic       wdtWake,
  input wire logic [7:0] wdtCount,
  input wire logic [7:0] wdtPostscale,
  input wire logic       sleeping,
  input wire logic       busy
);
  // ----
  // Checks
  // ----
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  wire reqTaken = wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
  wire instrWr  = reqTaken && wb_we_i && wb_adr_i[5:2] == `RSSE_ADR_INSTR && wb_sel_i[0];
  sequence quartersRun;
    busy [*4] ##1 !busy;
  endsequence
  a_ack_latency: assert property (reqTaken |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_four_quarters: assert property (
    instrWr && !busy && !sleeping |=> quartersRun) else $error("quarter sequence wrong");
  a_sleep_refuse: assert property (instrWr && sleeping |=> !busy)
    else $error("instruction ran while asleep");
  a_sleep_entry: assert property (
    $rose(sleeping) |-> $fell(busy) && wdtCount == 8'h00 && wdtPostscale == 8'h00)
    else $error("sleep entry wrong");
  a_wdt_frozen: assert property (sleeping && $past(sleeping) |-> wdtCount == 8'h00)
    else $error("watchdog moved in sleep");
  a_wake_exit: assert property (sleeping && wdtWake && !busy && clkEn |=> !sleeping)
    else $error("wake ignored");
  a_stay_asleep: assert property (sleeping && !wdtWake && clkEn |=> sleeping)
    else $error("left sleep without wake");
endmodule : rsse_core_monitor

// File: sim/tb_top.sv
// Bench for the rotate / set / sleep executor over Wishbone.
// Assumes rsse_core answers each access with a one-cycle ack.
`timescale 1ns/100ps
`include "rsse_defines.svh"
module tb_top import rsse_pkg::*;;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        clkEn = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wdtWake = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, sleeping, busy;
  logic [7:0]  wdtCount, wdtPostscale;
  logic [31:0] seed = 32'h8;
  logic [31:0] expQ[$];
  logic [7:0]  st, wr;
  int          mismatches = 0;
  int          samplesChecked = 0;

  rsse_core uut (.clock, .resetn, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wdtWake, .wdtCount, .wdtPostscale,
    .sleeping, .busy);

  always #20 clock = ~clock;

  // ----
  // Tasks
  // ----
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wbAccess(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clock);
  endtask : wbAccess

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    expQ.push_back(e);
    wbAccess(1'b0, a, 32'h0);
  endtask : rd

  // Waits on the busy port, bounded so a stuck executor still ends the run
  task automatic instr(input logic [15:0] w);
    int n;
    n = 0;
    wbAccess(1'b1, 6'h00, {16'h0, w});
    while (busy !== 1'b0 && n < 10) begin
      @(posedge clock);
      n++;
    end
    if (n >= 10) mismatches++;
  endtask : instr

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0) chk(wb_dat_o, expQ.pop_front());
  end

  initial begin
    #(40 * 4000);
    mismatches++;
    tally_and_finish();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    logic [7:0] v, r;
    logic       d;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    st = 8'h60;
    wr = 8'h00;
    rd(6'h04, 32'h60);
    wbAccess(1'b1, 6'h20, 32'hff);
    rd(6'h20, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = (i == 6) ? 8'h00 : xs();
      d = i[0];
      wbAccess(1'b1, 6'h18, 32'(i));
      wbAccess(1'b1, 6'h1c, {24'h0, v});
      r = (i < 4) ? {st[0], v[7:1]} : {v[0], v[7:1]};
      if (i < 4) st[0] = v[0];
      st[4] = r[7];
      st[2] = (r == 8'h00);
      if (!d) wr = r;
      instr({(i < 4) ? `RSSE_OP_RRC : `RSSE_OP_RRN, d, 1'b0, 8'(i)});
      rd(6'h04, {24'h0, st});
      rd(6'h08, {24'h0, wr});
      rd(6'h1c, {24'h0, d ? r : v});
    end
    wbAccess(1'b1, 6'h0c, 32'h3);
    instr({`RSSE_OP_SET, 1'b1, 8'h05});
    instr({`RSSE_OP_SET, 1'b0, 8'h85});
    wbAccess(1'b1, 6'h18, 32'h6);
    rd(6'h1c, 32'hff);
    wbAccess(1'b1, 6'h18, 32'ha);
    rd(6'h1c, 32'hff);
    rd(6'h04, {24'h0, st});
    instr(`RSSE_WORD_SLEEP);
    st[7:5] = 3'b110;
    rd(6'h04, {24'h0, st});
    rd(6'h10, 32'h0);
    instr({`RSSE_OP_RRN, 2'b00, 8'h01});
    rd(6'h08, {24'h0, wr});
    wdtWake <= 1'b1;
    @(posedge clock);
    wdtWake <= 1'b0;
    @(posedge clock);
    st[7:6] = 2'b00;
    rd(6'h04, {24'h0, st});
    repeat (2) @(posedge clock);
    tally_and_finish();
  end
endmodule : tb_top

bind rsse_core rsse_core_monitor mon (.clock, .resetn, .clkEn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_ack_o, .wdtWake, .wdtCount, .wdtPostscale,
  .sleeping, .busy);
